// file: sscd_pkg.sv
// Package for the stage sequence command decoder: widths, output count, states.
// Assumes one synchronous clock domain; no software registers.
package sscd_pkg;
	localparam int CMD_W        = 8;
	localparam int NUM_OUTPUTS  = 112;
	localparam int OUT_IDX_W    = 7;
	localparam logic [CMD_W-1:0] CMD_RESET = 8'h00;
	localparam logic [CMD_W-1:0] VERIFY_ALL_ON = 8'hff;
	localparam logic [NUM_OUTPUTS-1:0] OUT_NONE = '0;
	// Cycles the selected output is held active after a read
	localparam int FIRE_CYCLES  = 4;
	localparam int FIRE_CNT_W   = 3;
	typedef enum logic [1:0] {
		SSCD_IDLE,
		SSCD_LATCHED,
		SSCD_FIRE
	} sscd_state_t;
endpackage : sscd_pkg

// file: sscd_onehot.sv
// One-hot decoder from the stored command to the discrete output vector.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module sscd_onehot (
	input  wire logic [sscd_pkg::CMD_W-1:0]       code,
	input  wire logic                             enable,
	output logic      [sscd_pkg::NUM_OUTPUTS-1:0] onehot
);
	always_comb begin
		onehot = sscd_pkg::OUT_NONE;
		// Codes beyond the last channel select nothing
		if (enable && (code < 8'(sscd_pkg::NUM_OUTPUTS))) begin
			onehot[code[sscd_pkg::OUT_IDX_W-1:0]] = 1'b1;
		end
	end
endmodule : sscd_onehot
`default_nettype wire

// file: sscd_core.sv
// Stage sequence command decoder: latches a command on stage select, echoes it
// on the verify lines, fires the selected discrete output on read (none for codes 0x70 and up), then resets itself.
// Assumes all inputs are synchronous to core_clk.
// Contract
// - At most one of 112 outputs active, chosen by the stored command.
// - Verify lines read zero when reset, supply level when not reset; the code echoes the stored command there instead.
// - Command stored when stage select applied with address lines.
// - On read, decoder activates the output selected by stored command.
// - Read also starts automatic reset of latches and stage select.
// - Eight address lines, forced reset plus redundant copy, eight verify lines.
`timescale 1ns/1ps
`default_nettype none
module sscd_core (
	input  wire logic                             core_clk,
	input  wire logic                             sys_rst,
	input  wire logic                             clk_en,
	input  wire logic [sscd_pkg::CMD_W-1:0]       cmd_addr,
	input  wire logic                             stage_select,
	input  wire logic                             read_cmd,
	input  wire logic                             force_reset,
	input  wire logic                             force_reset_red,
	output logic      [sscd_pkg::CMD_W-1:0]       verify,
	output logic      [sscd_pkg::NUM_OUTPUTS-1:0] discrete_out,
	output logic                                  selected
);
	sscd_pkg::sscd_state_t            state_q;
	sscd_pkg::sscd_state_t            state_d;
	logic [sscd_pkg::CMD_W-1:0]       cmd_q;
	logic [sscd_pkg::CMD_W-1:0]       cmd_d;
	logic [sscd_pkg::FIRE_CNT_W-1:0]  cnt_q;
	logic [sscd_pkg::FIRE_CNT_W-1:0]  cnt_d;
	logic [sscd_pkg::NUM_OUTPUTS-1:0] out_q;
	logic [sscd_pkg::NUM_OUTPUTS-1:0] out_d;
	logic [sscd_pkg::CMD_W-1:0]       verify_q;
	logic [sscd_pkg::CMD_W-1:0]       verify_d;
	logic [sscd_pkg::NUM_OUTPUTS-1:0] dec;
	logic                             dec_en;
	logic                             frc;
	logic                             take_sel;
	logic                             take_read;
	logic                             firing;
	logic                             fire_done;

	// Idle test shared by select taking and the selected flag
	function automatic logic sscd_is_idle(input sscd_pkg::sscd_state_t s);
		return (s == sscd_pkg::SSCD_IDLE);
	endfunction : sscd_is_idle

	// Either copy of the forced reset line acts
	assign frc       = force_reset | force_reset_red;
	// Forced reset outranks a select or read in the same cycle
	assign take_sel  = sscd_is_idle(state_q) && stage_select && !frc;
	assign take_read = (state_q == sscd_pkg::SSCD_LATCHED) && read_cmd && !frc;
	assign firing    = (state_q == sscd_pkg::SSCD_FIRE);
	assign fire_done = firing && (cnt_q == '0);
	// Decoder only looks at the latches while a command waits for read
	assign dec_en    = (state_q == sscd_pkg::SSCD_LATCHED);

	sscd_onehot sscd_onehot_i (
		.code   (cmd_q),
		.enable (dec_en),
		.onehot (dec)
	);

	// Sequencer: idle, command held, output firing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sscd_pkg::SSCD_IDLE: begin
				if (take_sel) begin
					state_d = sscd_pkg::SSCD_LATCHED;
				end
			end
			sscd_pkg::SSCD_LATCHED: begin
				if (take_read) begin
					state_d = sscd_pkg::SSCD_FIRE;
				end
			end
			sscd_pkg::SSCD_FIRE: begin
				if (fire_done) begin
					state_d = sscd_pkg::SSCD_IDLE;
				end
			end
		endcase
		if (frc) begin
			state_d = sscd_pkg::SSCD_IDLE;
		end
	end

	// All registers hold while clk_en is low
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= sscd_pkg::SSCD_IDLE;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// Input latches: loaded on select, cleared by auto or forced reset
	always_comb begin
		cmd_d = cmd_q;
		unique case (state_q)
			sscd_pkg::SSCD_IDLE: begin
				if (take_sel) begin
					cmd_d = cmd_addr;
				end
			end
			sscd_pkg::SSCD_LATCHED: begin
				cmd_d = cmd_q;
			end
			sscd_pkg::SSCD_FIRE: begin
				if (fire_done) begin
					cmd_d = sscd_pkg::CMD_RESET;
				end
			end
		endcase
		if (frc) begin
			cmd_d = sscd_pkg::CMD_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmd_q <= sscd_pkg::CMD_RESET;
		end else if (clk_en) begin
			cmd_q <= cmd_d;
		end
	end

	// Pulse length counter
	always_comb begin
		cnt_d = cnt_q;
		unique case (state_q)
			sscd_pkg::SSCD_IDLE: begin
				cnt_d = '0;
			end
			sscd_pkg::SSCD_LATCHED: begin
				if (take_read) begin
					cnt_d = sscd_pkg::FIRE_CNT_W'(sscd_pkg::FIRE_CYCLES - 1);
				end
			end
			sscd_pkg::SSCD_FIRE: begin
				if (!fire_done) begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		endcase
		if (frc) begin
			cnt_d = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (clk_en) begin
			cnt_q <= cnt_d;
		end
	end

	// Discrete outputs: one channel for the pulse, none otherwise
	always_comb begin
		out_d = sscd_pkg::OUT_NONE;
		unique case (state_q)
			sscd_pkg::SSCD_IDLE: begin
				out_d = sscd_pkg::OUT_NONE;
			end
			sscd_pkg::SSCD_LATCHED: begin
				if (take_read) begin
					out_d = dec;
				end
			end
			sscd_pkg::SSCD_FIRE: begin
				// Hold the channel for the whole pulse
				if (!fire_done) begin
					out_d = out_q;
				end
			end
		endcase
		if (frc) begin
			out_d = sscd_pkg::OUT_NONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			out_q <= sscd_pkg::OUT_NONE;
		end else if (clk_en) begin
			out_q <= out_d;
		end
	end

	// Zero when reset; echo of the latches while a command is held
	always_comb begin
		verify_d = sscd_pkg::CMD_RESET;
		unique case (state_d)
			sscd_pkg::SSCD_IDLE: begin
				verify_d = sscd_pkg::CMD_RESET;
			end
			sscd_pkg::SSCD_LATCHED, sscd_pkg::SSCD_FIRE: begin
				verify_d = cmd_d;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			verify_q <= sscd_pkg::CMD_RESET;
		end else if (clk_en) begin
			verify_q <= verify_d;
		end
	end

	assign verify       = verify_q;
	assign discrete_out = out_q;
	assign selected     = !sscd_is_idle(state_q);
endmodule : sscd_core
`default_nettype wire

// file: sscd_assertions.sv
// Port checker for sscd_core.
// Assumes a bind onto every sscd_core.
`timescale 1ns/1ps
`default_nettype none
module sscd_assertions (
	input wire logic         core_clk,
	input wire logic         sys_rst,
	input wire logic         clk_en,
	input wire logic         stage_select,
	input wire logic         read_cmd,
	input wire logic         force_reset,
	input wire logic         force_reset_red,
	input wire logic         selected,
	input wire logic [7:0]   cmd_addr,
	input wire logic [7:0]   verify,
	input wire logic [111:0] discrete_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire f = force_reset | force_reset_red;
	property p_one; $onehot0(discrete_out); endproperty
	a_one: assert property (p_one) else $error("two outputs");
	property p_zero; !selected |-> verify == 8'h00; endproperty
	a_zero: assert property (p_zero) else $error("verify set");
	property p_lat; clk_en && stage_select && !selected && !f |=> verify == $past(cmd_addr); endproperty
	a_lat: assert property (p_lat) else $error("no latch");
	property p_fire; clk_en && read_cmd && selected && discrete_out == '0 && verify < 8'h70 && !f
		|=> discrete_out == 112'h1 << $past(verify); endproperty
	a_fire: assert property (p_fire) else $error("bad output");
	property p_auto; $fell(|discrete_out) |-> !selected && verify == 8'h00; endproperty
	a_auto: assert property (p_auto) else $error("no self reset");
	property p_frc; clk_en && f |=> !selected && discrete_out == '0; endproperty
	a_frc: assert property (p_frc) else $error("force failed");
	property p_red; clk_en && force_reset_red |=> verify == 8'h00; endproperty
	a_red: assert property (p_red) else $error("copy failed");
endmodule : sscd_assertions
bind sscd_core sscd_assertions sscd_assertions_i (.core_clk, .sys_rst, .clk_en, .stage_select,
	.read_cmd, .force_reset, .force_reset_red, .selected, .cmd_addr, .verify, .discrete_out);
`default_nettype wire

// file: sscd_host.sv
// Guidance computer model driving the decoder.
// Assumes calls from the bench; drives on falling edges.
`timescale 1ns/1ps
`default_nettype none
module sscd_host (
	input  wire logic       core_clk,
	input  wire logic [7:0] verify,
	output logic      [7:0] cmd_addr = 8'h00,
	output logic            stage_select = 1'b0,
	output logic            read_cmd = 1'b0,
	output logic            force_reset = 1'b0
);
	task frc;
		@(negedge core_clk) force_reset = 1;
		@(negedge core_clk) force_reset = 0;
	endtask : frc
	task sel(input logic [7:0] c);
		@(negedge core_clk) {stage_select, cmd_addr} = {1'b1, c};
		@(negedge core_clk) {stage_select, cmd_addr} = {1'b0, ~c};
	endtask : sel
	task send(input logic [7:0] c, input logic bad);
		@(negedge core_clk);
		for (int i = 0; i < 3 && verify !== 8'h00; i++) frc;
		sel(c);
		if (verify !== c || bad) begin
			frc;
			sel(~c);
		end
		@(negedge core_clk) read_cmd = 1;
		@(negedge core_clk) read_cmd = 0;
		repeat (6) @(negedge core_clk);
	endtask : send
endmodule : sscd_host
`default_nettype wire

// file: sscd_core_tb_top.sv
// Bench for sscd_core with the host model.
// Assumes a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sscd_core_tb_top;
	logic core_clk = 0, sys_rst = 1, frr = 0, ce = 1, stage_select, read_cmd, force_reset, selected;
	logic [7:0] cmd_addr, verify;
	logic [111:0] discrete_out, last = '0, q[$];
	logic [31:0] r = 32'hd18092f8;
	int miscompares = 0, n_compared = 0;
	always #5 core_clk = ~core_clk;
	sscd_core sscd_core_i (.core_clk, .sys_rst, .clk_en(ce), .cmd_addr, .stage_select, .read_cmd,
		.force_reset, .force_reset_red(frr), .verify, .discrete_out, .selected);
	sscd_host sscd_host_i (.core_clk, .verify, .cmd_addr, .stage_select, .read_cmd, .force_reset);
	function logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx
	task check(input logic [111:0] s, e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("Error at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask : check
	task give_verdict;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task go(input logic [7:0] c, input logic bad);
		logic [7:0] k;
		k = bad ? ~c : c;
		if (k < 8'h70) q.push_back(112'h1 << k);
		sscd_host_i.send(c, bad);
		check(verify, 8'h00);
		check(selected, 1'b0);
	endtask : go
	always @(negedge core_clk) begin
		if (discrete_out !== '0 && last === '0) check(discrete_out, q.size() ? q.pop_front() : '0);
		last = discrete_out;
	end
	initial begin
		repeat (3) @(negedge core_clk);
		sys_rst = 0;
		go(8'h00, 0);
		go(8'h6f, 0);
		go(8'h70, 0);
		go(8'h90, 1);
		repeat (6) begin
			r = nx(r);
			go(r[7:0], r[8]);
		end
		sscd_host_i.sel(8'h21);
		ce = 0;
		frr = 1;
		@(negedge core_clk) frr = 0;
		check(verify, 8'h21);
		check(selected, 1'b1);
		ce = 1;
		sscd_host_i.sel(8'h33);
		go(8'h12, 0);
		sscd_host_i.sel(8'h44);
		check(selected, 1'b1);
		frr = 1;
		@(negedge core_clk) frr = 0;
		check(verify, 8'h00);
		check(selected, 1'b0);
		check(q.size(), 0);
		give_verdict;
	end
endmodule : sscd_core_tb_top
`default_nettype wire
